/* pin_select_pkg.sv */
/*
 * constants, field layout and bus carrier for the remappable pin-select block.
 * assumes a single system clock and a plain strobe-style register port.
 */
// -----------------------------------------------------------------------------
// Operation
// - serial1 receive follows pin named by selector
// - input selector zero ties input low
// - serial selectors in bits 6-0, rest zero
// - pin 38 takes function from fourth register
// - pin 41 takes function from bits 13-8
// - pin 40 takes function from bits 5-0
// - output registers read bits 15-14, 7-6 zero
// -----------------------------------------------------------------------------
package pin_select_pkg;

    // -------------------------------------------------------------------------
    // bus geometry
    // -------------------------------------------------------------------------
    localparam int ADDR_W    = 4;     // register port address width
    localparam int DATA_W    = 16;    // register width
    localparam int IN_SEL_W  = 7;     // input selector field width
    localparam int OUT_SEL_W = 6;     // output selector field width
    localparam int OUT_PINS  = 4;     // remappable outputs 38 to 41

    // -------------------------------------------------------------------------
    // register offsets (16-bit words, byte addressed)
    // -------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ENC_SEL = 4'h0;  // encoder home/index
    localparam logic [ADDR_W-1:0] OFS_RX1_SEL = 4'h2;  // serial1 receive
    localparam logic [ADDR_W-1:0] OFS_RX2_SEL = 4'h4;  // serial2 receive
    localparam logic [ADDR_W-1:0] OFS_OUT_A   = 4'h6;  // pins 38 and 39
    localparam logic [ADDR_W-1:0] OFS_OUT_B   = 4'h8;  // pins 40 and 41

    // -------------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------------
    localparam int HOME_LSB   = 8;    // encoder home selector
    localparam int INDEX_LSB  = 0;    // encoder index selector
    localparam int RX_LSB     = 0;    // serial receive selectors
    localparam int OUT_LO_LSB = 0;    // pins 38 / 40
    localparam int OUT_HI_LSB = 8;    // pins 39 / 41

    // -------------------------------------------------------------------------
    // reset values and special codes
    // -------------------------------------------------------------------------
    localparam logic [IN_SEL_W-1:0]  IN_SEL_RST  = 7'h00;  // ground
    localparam logic [OUT_SEL_W-1:0] OUT_SEL_RST = 6'h00;  // no function
    localparam logic [DATA_W-1:0]    RD_RST      = 16'h0000;

    // -------------------------------------------------------------------------
    // register port request carrier
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;    // word byte address
        logic [DATA_W-1:0] wdata;   // write data
        logic              wr;      // write strobe
        logic              rd;      // read strobe
    } reg_req_type;

endpackage

/* remappable_pin_select.sv */
/*
 * remappable pin-select: software selectors route pins to peripheral
 * inputs and peripheral functions to output pins 38 to 41.
 * assumes inputs synchronous to clk_sys and a master that never waits.
 */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps

module remappable_pin_select (
    input  wire logic                               clk_sys,
    input  wire logic                               rst_n,
    input  pin_select_pkg::reg_req_type             bus_req,
    output logic [pin_select_pkg::DATA_W-1:0]       rd_data_reg,
    input  wire logic [(1<<pin_select_pkg::IN_SEL_W)-1:0]  pin_in,
    input  wire logic [(1<<pin_select_pkg::OUT_SEL_W)-1:0] func_out,
    output logic                                    encoder_home_in,
    output logic                                    encoder_index_in,
    output logic                                    serial1_receive_input,
    output logic                                    serial2_receive_input,
    output logic [pin_select_pkg::OUT_PINS-1:0]     pin_out,
    output logic [pin_select_pkg::OUT_PINS-1:0]     pin_oe_reg
);

    // -------------------------------------------------------------------------
    // selector storage
    // -------------------------------------------------------------------------
    localparam int IW = pin_select_pkg::IN_SEL_W;   // input code width
    localparam int OW = pin_select_pkg::OUT_SEL_W;  // output code width
    localparam int NO = pin_select_pkg::OUT_PINS;   // output pin count

    logic [IW-1:0] encoder_home_input_selector_reg;   // home selector
    logic [IW-1:0] encoder_home_input_selector_next;
    logic [IW-1:0] encoder_index_input_selector_reg;  // index selector
    logic [IW-1:0] encoder_index_input_selector_next;
    logic [IW-1:0] serial1_receive_selector_reg;      // serial1 receive
    logic [IW-1:0] serial1_receive_selector_next;
    logic [IW-1:0] serial2_receive_selector_reg;      // serial2 receive
    logic [IW-1:0] serial2_receive_selector_next;
    logic [OW-1:0] out_fn_reg  [NO];                  // index 0 is pin 38
    logic [OW-1:0] out_fn_next [NO];

    // -------------------------------------------------------------------------
    // register write decode
    // -------------------------------------------------------------------------
    // writes to unmapped offsets are dropped; bits outside fields are ignored
    always_comb begin
        encoder_home_input_selector_next  = encoder_home_input_selector_reg;
        encoder_index_input_selector_next = encoder_index_input_selector_reg;
        serial1_receive_selector_next     = serial1_receive_selector_reg;
        serial2_receive_selector_next     = serial2_receive_selector_reg;
        for (int i = 0; i < NO; i++) begin
            out_fn_next[i] = out_fn_reg[i];
        end
        if (bus_req.wr) begin
            case (bus_req.addr)
                pin_select_pkg::OFS_ENC_SEL: begin
                    encoder_home_input_selector_next  =
                        bus_req.wdata[pin_select_pkg::HOME_LSB +: IW];
                    encoder_index_input_selector_next =
                        bus_req.wdata[pin_select_pkg::INDEX_LSB +: IW];
                end
                pin_select_pkg::OFS_RX1_SEL: begin
                    // only bits 6-0 stored
                    serial1_receive_selector_next =
                        bus_req.wdata[pin_select_pkg::RX_LSB +: IW];
                end
                pin_select_pkg::OFS_RX2_SEL: begin
                    serial2_receive_selector_next =
                        bus_req.wdata[pin_select_pkg::RX_LSB +: IW];
                end
                pin_select_pkg::OFS_OUT_A: begin
                    // pin 38 from low field, pin 39 from high field
                    out_fn_next[0] = bus_req.wdata[pin_select_pkg::OUT_LO_LSB +: OW];
                    out_fn_next[1] = bus_req.wdata[pin_select_pkg::OUT_HI_LSB +: OW];
                end
                pin_select_pkg::OFS_OUT_B: begin
                    // pin 40 from low field, pin 41 from high field
                    out_fn_next[2] = bus_req.wdata[pin_select_pkg::OUT_LO_LSB +: OW];
                    out_fn_next[3] = bus_req.wdata[pin_select_pkg::OUT_HI_LSB +: OW];
                end
                default: begin
                    // unmapped: nothing stored
                end
            endcase
        end
    end

    // selectors clear on reset so nothing is routed before software acts
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            encoder_home_input_selector_reg  <= pin_select_pkg::IN_SEL_RST;
            encoder_index_input_selector_reg <= pin_select_pkg::IN_SEL_RST;
            serial1_receive_selector_reg     <= pin_select_pkg::IN_SEL_RST;
            serial2_receive_selector_reg     <= pin_select_pkg::IN_SEL_RST;
            for (int i = 0; i < NO; i++) begin
                out_fn_reg[i] <= pin_select_pkg::OUT_SEL_RST;
            end
        end else begin
            encoder_home_input_selector_reg  <= encoder_home_input_selector_next;
            encoder_index_input_selector_reg <= encoder_index_input_selector_next;
            serial1_receive_selector_reg     <= serial1_receive_selector_next;
            serial2_receive_selector_reg     <= serial2_receive_selector_next;
            for (int i = 0; i < NO; i++) begin
                out_fn_reg[i] <= out_fn_next[i];
            end
        end
    end

    // -------------------------------------------------------------------------
    // register read path
    // -------------------------------------------------------------------------
    logic [pin_select_pkg::DATA_W-1:0] rd_data_next;   // read word

    // data valid only in the cycle after the read strobe; zero otherwise
    always_comb begin
        rd_data_next = pin_select_pkg::RD_RST;
        if (bus_req.rd) begin
            case (bus_req.addr)
                pin_select_pkg::OFS_ENC_SEL: begin
                    rd_data_next[pin_select_pkg::HOME_LSB +: IW]  = encoder_home_input_selector_reg;
                    rd_data_next[pin_select_pkg::INDEX_LSB +: IW] = encoder_index_input_selector_reg;
                end
                pin_select_pkg::OFS_RX1_SEL: begin
                    // bits 15-7 stay zero
                    rd_data_next[pin_select_pkg::RX_LSB +: IW] = serial1_receive_selector_reg;
                end
                pin_select_pkg::OFS_RX2_SEL: begin
                    rd_data_next[pin_select_pkg::RX_LSB +: IW] = serial2_receive_selector_reg;
                end
                pin_select_pkg::OFS_OUT_A: begin
                    // bits 15-14 and 7-6 stay zero
                    rd_data_next[pin_select_pkg::OUT_LO_LSB +: OW] = out_fn_reg[0];
                    rd_data_next[pin_select_pkg::OUT_HI_LSB +: OW] = out_fn_reg[1];
                end
                pin_select_pkg::OFS_OUT_B: begin
                    rd_data_next[pin_select_pkg::OUT_LO_LSB +: OW] = out_fn_reg[2];
                    rd_data_next[pin_select_pkg::OUT_HI_LSB +: OW] = out_fn_reg[3];
                end
                default: begin
                    // unmapped reads return zero
                    rd_data_next = pin_select_pkg::RD_RST;
                end
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= pin_select_pkg::RD_RST;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // -------------------------------------------------------------------------
    // peripheral input routing
    // -------------------------------------------------------------------------
    // pin_in bit n is remappable input pin n; bit 0 is never used since
    // code zero means ground, which the selector handles itself

    sel_mux #(.SEL_W(IW)) home_mux (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sel     (encoder_home_input_selector_reg),
        .src     (pin_in),
        .out_reg (encoder_home_in)
    );

    sel_mux #(.SEL_W(IW)) index_mux (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sel     (encoder_index_input_selector_reg),
        .src     (pin_in),
        .out_reg (encoder_index_in)
    );

    // serial1 receive follows the chosen pin, e.g. code 7'h79 picks pin 121
    sel_mux #(.SEL_W(IW)) rx1_mux (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sel     (serial1_receive_selector_reg),
        .src     (pin_in),
        .out_reg (serial1_receive_input)
    );

    sel_mux #(.SEL_W(IW)) rx2_mux (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sel     (serial2_receive_selector_reg),
        .src     (pin_in),
        .out_reg (serial2_receive_input)
    );

    // -------------------------------------------------------------------------
    // output pin routing
    // -------------------------------------------------------------------------
    // function zero means no peripheral: pin low and not driven
    genvar g;
    generate
        for (g = 0; g < NO; g++) begin : g_out
            sel_mux #(.SEL_W(OW)) out_mux (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .sel     (out_fn_reg[g]),
                .src     (func_out),
                .out_reg (pin_out[g])
            );
        end
    endgenerate

    logic [NO-1:0] pin_oe_next;   // drive enables

    // enable tracks a non-zero function, same latency as the data
    always_comb begin
        for (int i = 0; i < NO; i++) begin
            pin_oe_next[i] = (out_fn_reg[i] != pin_select_pkg::OUT_SEL_RST);
        end
    end

    // enables off from reset until a function is chosen
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_reg <= '0;
        end else begin
            pin_oe_reg <= pin_oe_next;
        end
    end

endmodule

/* remappable_pin_select_chk.sv */
/*
 * port-level checker for the remappable pin-select block.
 * assumes single clk_sys domain; bound to the top module below.
 */
`timescale 1ns/1ps

module remappable_pin_select_chk (
    input  wire logic                                      clk_sys,
    input  wire logic                                      rst_n,
    input  pin_select_pkg::reg_req_type                    bus_req,
    input  wire logic [pin_select_pkg::DATA_W-1:0]         rd_data_reg,
    input  wire logic [(1<<pin_select_pkg::IN_SEL_W)-1:0]  pin_in,
    input  wire logic [(1<<pin_select_pkg::OUT_SEL_W)-1:0] func_out,
    input  wire logic                                      encoder_home_in,
    input  wire logic                                      encoder_index_in,
    input  wire logic                                      serial1_receive_input,
    input  wire logic                                      serial2_receive_input,
    input  wire logic [pin_select_pkg::OUT_PINS-1:0]       pin_out,
    input  wire logic [pin_select_pkg::OUT_PINS-1:0]       pin_oe_reg
);
    // -------------------------------------------------------------------------
    // shadow copy of the selectors, rebuilt from bus writes
    // -------------------------------------------------------------------------
    logic [15:0]  shadow_reg [5];  // masked register images
    logic [15:0]  shadow_next [5]; // next images
    logic [15:0]  rd_exp;          // expected read data for current address
    logic [1:0]   exp_enc;         // home, index
    logic         exp_rx1;         // serial1 receive
    logic         exp_p38;         // pin 38
    logic         exp_p40;         // pin 40
    logic         exp_p41;         // pin 41
    logic [3:0]   exp_oe;          // drive enables
    logic [127:0] func_wide;       // functions widened to pin width

    // implemented bits per address; zero marks an unmapped place
    function automatic logic [15:0] field_mask(input logic [3:0] a);
        case (a)
            4'h0: return 16'h7F7F;
            4'h2, 4'h4: return 16'h007F;
            4'h6, 4'h8: return 16'h3F3F;
            default: return 16'h0000;
        endcase
    endfunction

    // code zero grounds the route instead of picking bit zero
    function automatic logic pick(input logic [6:0] c, input logic [127:0] s);
        return (c == 7'h00) ? 1'b0 : s[c];
    endfunction

    // next images: only mapped writes land
    always_comb begin
        shadow_next = shadow_reg;
        if (bus_req.wr && field_mask(bus_req.addr) != 16'h0000) begin
            shadow_next[bus_req.addr[3:1]] = bus_req.wdata & field_mask(bus_req.addr);
        end
    end

    // register images, cleared with the design
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 5; i++) shadow_reg[i] <= 16'h0000;
        end else begin
            shadow_reg <= shadow_next;
        end
    end

    assign func_wide = {64'h0, func_out};
    assign rd_exp    = (field_mask(bus_req.addr) != 16'h0000) ? shadow_reg[bus_req.addr[3:1]] : 16'h0000;
    assign exp_enc   = {pick(shadow_reg[0][14:8], pin_in), pick(shadow_reg[0][6:0], pin_in)};
    assign exp_rx1   = pick(shadow_reg[1][6:0], pin_in);
    assign exp_p38   = pick({1'b0, shadow_reg[3][5:0]}, func_wide);
    assign exp_p40   = pick({1'b0, shadow_reg[4][5:0]}, func_wide);
    assign exp_p41   = pick({1'b0, shadow_reg[4][13:8]}, func_wide);
    assign exp_oe    = {shadow_reg[4][13:8] != 6'h00, shadow_reg[4][5:0] != 6'h00,
                        shadow_reg[3][13:8] != 6'h00, shadow_reg[3][5:0] != 6'h00};

    // -------------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence read_taken;
        bus_req.rd;
    endsequence
    sequence out_read;
        bus_req.rd && (bus_req.addr == 4'h6 || bus_req.addr == 4'h8);
    endsequence

    rx1_route_a: assert property (serial1_receive_input == $past(exp_rx1))
        else $error("serial1 receive route differs");
    enc_ground_a: assert property ({encoder_home_in, encoder_index_in} == $past(exp_enc))
        else $error("encoder input route differs");
    read_data_a: assert property (read_taken |=> rd_data_reg == $past(rd_exp))
        else $error("read data differs");
    read_idle_a: assert property (!bus_req.rd |=> rd_data_reg == 16'h0000)
        else $error("read data without read");
    pin38_route_a: assert property (pin_out[0] == $past(exp_p38))
        else $error("pin 38 route differs");
    pin41_route_a: assert property (pin_out[3] == $past(exp_p41))
        else $error("pin 41 route differs");
    pin40_route_a: assert property (pin_out[2] == $past(exp_p40))
        else $error("pin 40 route differs");
    unused_zero_a: assert property (out_read |=> (rd_data_reg & 16'hC0C0) == 16'h0000)
        else $error("unused output bits read set");
    drive_enable_a: assert property (pin_oe_reg == $past(exp_oe))
        else $error("drive enable differs");
    reset_clear_a: assert property ($rose(rst_n) |-> pin_oe_reg == 4'h0 && pin_out == 4'h0
                                    && rd_data_reg == 16'h0000 && !encoder_home_in && !encoder_index_in
                                    && !serial1_receive_input && !serial2_receive_input)
        else $error("outputs not clear after reset");
endmodule

bind remappable_pin_select remappable_pin_select_chk i_chk (
    .clk_sys, .rst_n, .bus_req, .rd_data_reg, .pin_in, .func_out, .encoder_home_in, .encoder_index_in,
    .serial1_receive_input, .serial2_receive_input, .pin_out, .pin_oe_reg
);

/* sel_mux.sv */
/*
 * one registered pin/function selector: picks one source bit by code.
 * assumes sources synchronous to clk_sys; code zero always yields low.
 */
`timescale 1ns/1ps

module sel_mux #(
    parameter int SEL_W = 7            // selector code width
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [SEL_W-1:0]      sel,
    input  wire logic [(1<<SEL_W)-1:0] src,
    output logic                       out_reg
);

    // -------------------------------------------------------------------------
    // selection
    // -------------------------------------------------------------------------
    logic out_next;   // value for next edge

    // code zero is ground, any other code indexes the source vector
    always_comb begin
        if (sel == '0) begin
            out_next = 1'b0;
        end else begin
            out_next = src[sel];
        end
    end

    // registered so every routed signal leaves from a flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

endmodule

/* test_remappable_pin_select.sv */
/*
 * self-checking bench for the remappable pin-select block.
 * assumes the package constants; expectations come from a local model.
 */
`timescale 1ns/1ps

module test_remappable_pin_select;
    logic                        clk_sys    = 1'b0;
    logic                        rst_n      = 1'b0;
    pin_select_pkg::reg_req_type bus_req    = '0;
    logic [127:0]                pin_in     = '0;
    logic [63:0]                 func_out   = '0;
    logic [15:0]                 rd_data_reg;
    logic                        home, index, rx1, rx2;
    logic [3:0]                  pin_out, pin_oe_reg;
    logic [15:0]                 model_reg [5];   // expected register images
    logic [11:0]                 route_q [$];     // expected routed outputs
    logic [15:0]                 read_q [$];      // expected read data
    logic                        route_v    = 1'b0;
    logic                        route_d    = 1'b0;
    logic                        read_d     = 1'b0;
    int                          bad_count  = 0;
    int                          num_checks = 0;

    always #25 clk_sys = ~clk_sys;

    remappable_pin_select i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rd_data_reg(rd_data_reg),
        .pin_in(pin_in), .func_out(func_out), .encoder_home_in(home), .encoder_index_in(index),
        .serial1_receive_input(rx1), .serial2_receive_input(rx2), .pin_out(pin_out), .pin_oe_reg(pin_oe_reg)
    );

    function automatic logic [15:0] mask_of(input logic [3:0] a);
        case (a)
            4'h0: return 16'h7F7F;
            4'h2, 4'h4: return 16'h007F;
            4'h6, 4'h8: return 16'h3F3F;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic pick(input logic [6:0] c, input logic [127:0] s);
        return (c == 7'h00) ? 1'b0 : s[c];
    endfunction

    // expected {home, index, rx1, rx2, pin_out, oe} one edge after these sources
    function automatic logic [11:0] route_exp(input logic [127:0] pi, input logic [63:0] fo);
        return {pick(model_reg[0][14:8], pi), pick(model_reg[0][6:0], pi), pick(model_reg[1][6:0], pi),
                pick(model_reg[2][6:0], pi), pick({1'b0, model_reg[4][13:8]}, {64'h0, fo}),
                pick({1'b0, model_reg[4][5:0]}, {64'h0, fo}), pick({1'b0, model_reg[3][13:8]}, {64'h0, fo}),
                pick({1'b0, model_reg[3][5:0]}, {64'h0, fo}), model_reg[4][13:8] != 6'h00,
                model_reg[4][5:0] != 6'h00, model_reg[3][13:8] != 6'h00, model_reg[3][5:0] != 6'h00};
    endfunction

    // one bus cycle with fresh random sources; notes what must follow
    task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        logic [127:0] pi;
        logic [63:0]  fo;
        @(posedge clk_sys);
        pi = {$urandom, $urandom, $urandom, $urandom};
        fo = {$urandom, $urandom};
        pin_in   <= pi;
        func_out <= fo;
        bus_req  <= '{addr: a, wdata: d, wr: w, rd: r};
        route_v  <= 1'b1;
        route_q.push_back(route_exp(pi, fo));
        if (r) read_q.push_back((mask_of(a) != 16'h0000) ? model_reg[a[3:1]] : 16'h0000);
        if (w && mask_of(a) != 16'h0000) model_reg[a[3:1]] = d & mask_of(a);
    endtask

    // bus idle and checks drained
    task automatic quiet();
        @(posedge clk_sys);
        bus_req <= '0;
        route_v <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic do_reset();
        quiet();
        rst_n <= 1'b0;
        route_q.delete();
        read_q.delete();
        foreach (model_reg[i]) model_reg[i] = 16'h0000;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask

    task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value read data expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_route(input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value routed outputs expected %h seen %h", e, g);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // watcher: results land one edge after their cause
    // -------------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            route_d <= 1'b0;
            read_d  <= 1'b0;
        end else begin
            route_d <= route_v;
            read_d  <= bus_req.rd;
        end
    end

    always @(negedge clk_sys) begin
        if (route_d) chk_route(route_q.pop_front(), {home, index, rx1, rx2, pin_out, pin_oe_reg});
        if (read_d) chk_rd(read_q.pop_front(), rd_data_reg);
    end

    // hang guard, well beyond the ~1100 cycles of traffic
    initial begin
        repeat (6000) @(posedge clk_sys);
        bad_count++;
        stop_test();
    end

    initial begin
        int op;
        void'($urandom(35200));
        // opening reset: exactly 20 cycles low, bus already idle from its initialiser
        foreach (model_reg[i]) model_reg[i] = 16'h0000;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) cyc(1'b0, 1'b1, a[3:0], 16'h0000);
        cyc(1'b1, 1'b0, 4'h2, 16'h0079);
        repeat (20) cyc(1'b0, 1'b0, 4'h0, 16'h0000);
        for (int a = 0; a < 16; a++) begin
            cyc(1'b1, 1'b0, a[3:0], 16'hFFFF);
            cyc(1'b0, 1'b1, a[3:0], 16'h0000);
        end
        // every input and output code, with stray bits beside the fields
        for (int c = 0; c < 128; c++) begin
            cyc(1'b1, 1'b0, 4'h0, {1'b1, c[6:0], 1'b1, ~c[6:0]});
            cyc(1'b1, 1'b0, 4'h2, c[15:0]);
            cyc(1'b1, 1'b0, 4'h4, ~c[15:0]);
            cyc(1'b1, 1'b0, 4'h6, {c[7:0], ~c[7:0]});
            cyc(1'b1, 1'b1 & 1'b0, 4'h8, {~c[7:0], c[7:0]});
        end
        repeat (300) begin
            op = $urandom_range(2);
            cyc(op == 1, op == 2, 4'($urandom), 16'($urandom));
        end
        for (int a = 0; a < 10; a += 2) cyc(1'b1, 1'b0, a[3:0], 16'h0000);
        repeat (10) cyc(1'b0, 1'b0, 4'h0, 16'h0000);
        do_reset();
        for (int a = 0; a < 10; a += 2) cyc(1'b0, 1'b1, a[3:0], 16'h0000);
        quiet();
        stop_test();
    end
endmodule
